//--- pkg/stc_pkg.sv
// Shared constants, types and mode decode for the sixteen-bit timer capture core
package stc_pkg;

  // ==========================================================
  // Types
  typedef logic [15:0] stc_word_t;
  typedef logic [7:0]  stc_byte_t;
  typedef logic [2:0]  stc_addr_t;
  typedef logic [3:0]  stc_mode_t;
  typedef logic [2:0]  stc_csel_t;

  // ==========================================================
  // Byte locations on the CPU access port
  localparam stc_addr_t ADDR_CNT_LO = 3'h0;
  localparam stc_addr_t ADDR_CNT_HI = 3'h1;
  localparam stc_addr_t ADDR_CAP_LO = 3'h2;
  localparam stc_addr_t ADDR_CAP_HI = 3'h3;
  localparam stc_addr_t ADDR_CMP_LO = 3'h4;
  localparam stc_addr_t ADDR_CMP_HI = 3'h5;

  // ==========================================================
  // Reset values and fixed counter limits
  localparam stc_word_t WORD_RST = 16'h0000;
  localparam stc_byte_t BYTE_RST = 8'h00;
  localparam stc_word_t VAL_MAX  = 16'hffff;
  localparam stc_word_t TOP_8    = 16'h00ff;
  localparam stc_word_t TOP_9    = 16'h01ff;
  localparam stc_word_t TOP_10   = 16'h03ff;
  localparam stc_word_t STEP     = 16'h0001;

  // ==========================================================
  // Clock source selection
  localparam stc_csel_t   CS_STOPPED   = 3'h0;
  localparam stc_csel_t   CS_FIRST     = 3'h1;
  localparam int unsigned NUM_TICK_SRC = 7;

  // ==========================================================
  // Waveform mode codes
  localparam stc_mode_t MODE_NORMAL   = 4'h0;
  localparam stc_mode_t MODE_PC8      = 4'h1;
  localparam stc_mode_t MODE_PC9      = 4'h2;
  localparam stc_mode_t MODE_PC10     = 4'h3;
  localparam stc_mode_t MODE_CTC_CMP  = 4'h4;
  localparam stc_mode_t MODE_FAST8    = 4'h5;
  localparam stc_mode_t MODE_FAST9    = 4'h6;
  localparam stc_mode_t MODE_FAST10   = 4'h7;
  localparam stc_mode_t MODE_PFC_CAP  = 4'h8;
  localparam stc_mode_t MODE_PFC_CMP  = 4'h9;
  localparam stc_mode_t MODE_PC_CAP   = 4'ha;
  localparam stc_mode_t MODE_PC_CMP   = 4'hb;
  localparam stc_mode_t MODE_CTC_CAP  = 4'hc;
  localparam stc_mode_t MODE_FAST_CAP = 4'he;
  localparam stc_mode_t MODE_FAST_CMP = 4'hf;

  // ==========================================================
  // Mode decode
  // Highest value of the count sequence for a mode
  function automatic stc_word_t stc_top(input stc_mode_t m, input stc_word_t cmp, input stc_word_t cap);
    case (m)
      MODE_PC8, MODE_FAST8:   stc_top = TOP_8;
      MODE_PC9, MODE_FAST9:   stc_top = TOP_9;
      MODE_PC10, MODE_FAST10: stc_top = TOP_10;
      MODE_CTC_CMP, MODE_PFC_CMP, MODE_PC_CMP, MODE_FAST_CMP: stc_top = cmp;
      MODE_PFC_CAP, MODE_PC_CAP, MODE_CTC_CAP, MODE_FAST_CAP: stc_top = cap;
      default:                stc_top = VAL_MAX;
    endcase
  endfunction

  // Up-down counting modes
  function automatic logic stc_dual(input stc_mode_t m);
    stc_dual = m inside {MODE_PC8, MODE_PC9, MODE_PC10, MODE_PFC_CAP, MODE_PFC_CMP, MODE_PC_CAP, MODE_PC_CMP};
  endfunction

  // Single-slope modes that flag overflow at the top
  function automatic logic stc_fast(input stc_mode_t m);
    stc_fast = m inside {MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAP, MODE_FAST_CMP};
  endfunction

  // Modes where the capture register holds the top
  function automatic logic stc_cap_top(input stc_mode_t m);
    stc_cap_top = m inside {MODE_PFC_CAP, MODE_PC_CAP, MODE_CTC_CAP, MODE_FAST_CAP};
  endfunction

endpackage

//--- hdl/stc_capture_in.sv
// Capture trigger conditioning: synchronise, select source, detect edge
`timescale 1ns/1ps

module stc_capture_in
  import stc_pkg::*;
#(
  parameter int TIMER_INDEX = 1
)
(
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  input  wire logic cmp_i,
  input  wire logic use_cmp_i,
  input  wire logic rising_i,
  input  wire logic enable_i,
  output logic      capture_o
);

  // Only the first timer may be fed by the comparator
  localparam bit CMP_OK = (TIMER_INDEX == 1);

  logic [1:0] pin_sync;
  logic [1:0] cmp_sync;
  logic       src;
  logic       prev;

  // ==========================================================
  // Synchronisers
  // Both sources are foreign to this clock, so each gets two flops
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_sync <= 2'h0;
      cmp_sync <= 2'h0;
    end
    else if (ce_i)
    begin
      pin_sync <= {pin_sync[0], pin_i};
      cmp_sync <= {cmp_sync[0], cmp_i};
    end
  end

  assign src = (CMP_OK && use_cmp_i) ? cmp_sync[1] : pin_sync[1];

  // ==========================================================
  // Edge detector
  // A source switch may look like an edge; software clears the flag after
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prev      <= 1'b0;
      capture_o <= 1'b0;
    end
    else if (ce_i)
    begin
      prev <= src;
      capture_o <= enable_i && (src != prev) && (src == rising_i);
    end
  end

  // ==========================================================
  // Checks
  // Whenever the pin is the source, a quiet pin gives no capture
  a_pin_only: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && (!CMP_OK || !use_cmp_i) && (pin_sync[1] == prev)) |=> !capture_o)
    else $error("capture with no pin edge while the pin is the source");

  a_edge_fires: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && enable_i && !use_cmp_i && $rose(pin_sync[1]) && rising_i) |=> capture_o)
    else $error("matching pin edge gave no capture");

endmodule

//--- hdl/stc_core.sv
// Sixteen-bit timer counter with staged byte access and input capture
`timescale 1ns/1ps

// Operation
// - Low-byte read stages counter upper byte; low-byte write loads it from staging.
// - Three-bit clock source field picks tick; zero stops the counter.
// - Each tick the counter clears, increments or decrements by one per mode.
// - Counter stays readable and writable with or without any tick.
// - A CPU counter write beats any clear or count in that cycle.
// - Four-bit waveform mode, split over control A and B, picks the sequence.
// - Overflow flag sets at the mode's point and serves as interrupt request.
// - Floor shows counter zero, ceiling shows top; clear zeroes all bits.
// - Capture fires when pin or comparator change matches the edge setting.
// - Comparator trigger exists only on timer one; timer three uses pin only.
// - Capture copies the full counter and sets the flag in one cycle.
// - Capture flag requests interrupt only when enabled; servicing clears it.
// - Writing one to the capture flag clears it.
// - Capture low byte read first stages upper byte; upper read returns staging.
// - Capture register takes writes only in modes using it as top.
// - One staging byte serves every sixteen-bit register of the timer.
// - Compare register reads return both bytes directly, bypassing staging.

module stc_core
  import stc_pkg::*;
#(
  parameter int TIMER_INDEX = 1
)
(
  input  wire logic                    MCLK_I,
  input  wire logic                    RST_B_I,
  input  wire logic                    CE_I,
  input  wire stc_addr_t               IO_ADDR_I,
  input  wire logic                    IO_RD_I,
  input  wire logic                    IO_WR_I,
  input  wire stc_byte_t               IO_WDATA_I,
  input  wire stc_csel_t               CLOCK_SOURCE_I,
  input  wire logic [NUM_TICK_SRC-1:0] TICK_SRC_I,
  input  wire logic [1:0]              MODE_LOW_I,
  input  wire logic [1:0]              MODE_HIGH_I,
  input  wire logic                    CAPTURE_PIN_I,
  input  wire logic                    COMPARATOR_OUTPUT_I,
  input  wire logic                    COMPARATOR_SELECT_I,
  input  wire logic                    CAPTURE_RISING_I,
  input  wire logic                    CAPTURE_IRQ_ENABLE_I,
  input  wire logic                    CAPTURE_FLAG_CLEAR_I,
  input  wire logic                    CAPTURE_IRQ_ACK_I,
  input  wire logic                    OVERFLOW_FLAG_CLEAR_I,
  input  wire logic                    OVERFLOW_IRQ_ACK_I,
  output stc_byte_t                    IO_RDATA_O,
  output logic                         OVERFLOW_FLAG_O,
  output logic                         CAPTURE_FLAG_O,
  output logic                         CAPTURE_IRQ_O,
  output logic                         FLOOR_O,
  output logic                         CEILING_O
);

  stc_word_t count;
  stc_word_t next_count;
  stc_word_t capture;
  stc_word_t compare;
  stc_byte_t staging;
  stc_mode_t mode;
  stc_word_t top;
  logic      down;
  logic      next_down;
  logic      tick;
  logic      cnt_clear;
  logic      cnt_count;
  logic      cnt_up;
  logic      ovf_evt;
  logic      cap_evt;
  logic      cnt_wr;
  logic      cap_wr;
  logic      cmp_wr;
  logic      hi_wr;
  logic      next_cflag;
  logic      next_oflag;

  // ==========================================================
  // Mode, top and tick selection
  // split mode field
  assign mode = {MODE_HIGH_I, MODE_LOW_I};
  assign top  = stc_top(mode, compare, capture);

  // Tick sources are prescaler taps already on this clock, so no sync
  // source select and stop
  assign tick = (CLOCK_SOURCE_I != CS_STOPPED) && TICK_SRC_I[CLOCK_SOURCE_I - CS_FIRST];

  // Byte strobes
  assign cnt_wr = IO_WR_I && (IO_ADDR_I == ADDR_CNT_LO);
  assign cap_wr = IO_WR_I && (IO_ADDR_I == ADDR_CAP_LO) && stc_cap_top(mode);
  assign cmp_wr = IO_WR_I && (IO_ADDR_I == ADDR_CMP_LO);
  assign hi_wr  = IO_WR_I && (IO_ADDR_I inside {ADDR_CNT_HI, ADDR_CAP_HI, ADDR_CMP_HI});

  // ==========================================================
  // Counter controls: clear, count and direction
  // per-mode count control
  always_comb
  begin
    cnt_clear = 1'b0;
    cnt_count = 1'b0;
    cnt_up    = 1'b1;
    next_down = down;
    ovf_evt   = 1'b0;
    if (tick)
    begin
      if (stc_dual(mode))
      begin
        cnt_count = 1'b1;
        if (down && (count == WORD_RST))
        begin
          next_down = 1'b0;
          ovf_evt   = 1'b1;
        end
        else if (!down && (count >= top))
        begin
          next_down = 1'b1;
        end
        cnt_up = !next_down;
      end
      else if ((count == top) || (count == VAL_MAX))
      begin
        cnt_clear = 1'b1;
        // fast at top, others at max
        ovf_evt = stc_fast(mode) || (count == VAL_MAX);
      end
      else
      begin
        cnt_count = 1'b1;
      end
    end
  end

  // Next counter value; the CPU write wins over everything
  always_comb
  begin
    if (cnt_wr)
      next_count = {staging, IO_WDATA_I};
    else if (cnt_clear)
      next_count = WORD_RST;
    else if (cnt_count)
      next_count = cnt_up ? count + STEP : count - STEP;
    else
      next_count = count;
  end

  // ==========================================================
  // Counter state
  // counter update, tick or not
  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      count <= WORD_RST;
      down  <= 1'b0;
    end
    else if (CE_I)
    begin
      count <= next_count;
      down  <= cnt_wr ? down : next_down;
    end
  end

  // Floor and ceiling follow the value the counter takes
  // floor and ceiling
  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      FLOOR_O   <= 1'b1;
      CEILING_O <= 1'b0;
    end
    else if (CE_I)
    begin
      FLOOR_O   <= (next_count == WORD_RST);
      CEILING_O <= (next_count == top);
    end
  end

  // ==========================================================
  // Staging byte shared by all three registers
  // Interrupt code touching it mid-access corrupts the main code's pair
  // single shared staging
  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      staging <= BYTE_RST;
    else if (CE_I)
    begin
      if (hi_wr)
        staging <= IO_WDATA_I;
      else if (IO_RD_I && (IO_ADDR_I == ADDR_CNT_LO))
        staging <= count[15:8];
      else if (IO_RD_I && (IO_ADDR_I == ADDR_CAP_LO))
        staging <= capture[15:8];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      IO_RDATA_O <= BYTE_RST;
    else if (CE_I && IO_RD_I)
    begin
      case (IO_ADDR_I)
        ADDR_CNT_LO: IO_RDATA_O <= count[7:0];
        ADDR_CNT_HI: IO_RDATA_O <= staging;
        ADDR_CAP_LO: IO_RDATA_O <= capture[7:0];
        ADDR_CAP_HI: IO_RDATA_O <= staging;
        ADDR_CMP_LO: IO_RDATA_O <= compare[7:0];
        ADDR_CMP_HI: IO_RDATA_O <= compare[15:8];
        default:     IO_RDATA_O <= BYTE_RST;
      endcase
    end
  end

  // ==========================================================
  // Compare and capture registers
  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      compare <= WORD_RST;
    else if (CE_I && cmp_wr)
      compare <= {staging, IO_WDATA_I};
  end

  // Capture input is off while the register defines the top
  stc_capture_in #(
    .TIMER_INDEX (TIMER_INDEX)
  ) u_capture_in (
    .mclk_i    (MCLK_I),
    .rst_b_i   (RST_B_I),
    .ce_i      (CE_I),
    .pin_i     (CAPTURE_PIN_I),
    .cmp_i     (COMPARATOR_OUTPUT_I),
    .use_cmp_i (COMPARATOR_SELECT_I),
    .rising_i  (CAPTURE_RISING_I),
    .enable_i  (!stc_cap_top(mode)),
    .capture_o (cap_evt)
  );

  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      capture <= WORD_RST;
    else if (CE_I)
    begin
      if (cap_evt)
        capture <= count;
      else if (cap_wr)
        capture <= {staging, IO_WDATA_I};
    end
  end

  // ==========================================================
  // Flags; an event in the clearing cycle still sets the flag
  // write-one clear, set wins
  assign next_cflag = cap_evt || (CAPTURE_FLAG_O && !(CAPTURE_FLAG_CLEAR_I || CAPTURE_IRQ_ACK_I));
  assign next_oflag = (ovf_evt && !cnt_wr) || (OVERFLOW_FLAG_O && !(OVERFLOW_FLAG_CLEAR_I || OVERFLOW_IRQ_ACK_I));

  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      CAPTURE_FLAG_O  <= 1'b0;
      OVERFLOW_FLAG_O <= 1'b0;
    end
    else if (CE_I)
    begin
      CAPTURE_FLAG_O  <= next_cflag;
      OVERFLOW_FLAG_O <= next_oflag;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      CAPTURE_IRQ_O <= 1'b0;
    else if (CE_I)
      CAPTURE_IRQ_O <= next_cflag && CAPTURE_IRQ_ENABLE_I;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);

  a_low_read_stage: assert property (
    (CE_I && IO_RD_I && (IO_ADDR_I == ADDR_CNT_LO)) |=> (staging == $past(count[15:8])))
    else $error("counter low read did not stage upper byte");

  a_stopped_holds: assert property (
    (CE_I && (CLOCK_SOURCE_I == CS_STOPPED) && !cnt_wr) |=> (count == $past(count)))
    else $error("counter moved with no clock source");

  a_normal_step: assert property (
    (CE_I && tick && !cnt_wr && (mode == MODE_NORMAL) && (count != VAL_MAX)) |=> (count == $past(count) + STEP))
    else $error("normal mode did not increment");

  a_write_wins: assert property (
    (CE_I && cnt_wr) |=> (count == {$past(staging), $past(IO_WDATA_I)}))
    else $error("counter write lost to count or clear");

  a_overflow_max: assert property (
    (CE_I && tick && !cnt_wr && (mode == MODE_NORMAL) && (count == VAL_MAX)) |=> (OVERFLOW_FLAG_O && FLOOR_O))
    else $error("wrap gave no overflow flag");

  a_floor_match: assert property (
    FLOOR_O == (count == WORD_RST))
    else $error("floor does not match counter zero");

  a_capture_copy: assert property (
    (CE_I && cap_evt) |=> (CAPTURE_FLAG_O && (capture == $past(count))))
    else $error("capture copy or flag missing");

  a_irq_gated: assert property (
    $rose(CAPTURE_IRQ_O) |-> ($past(CAPTURE_IRQ_ENABLE_I) && CAPTURE_FLAG_O))
    else $error("capture request without enable");

  a_flag_clear: assert property (
    (CE_I && CAPTURE_FLAG_CLEAR_I && !cap_evt) |=> !CAPTURE_FLAG_O)
    else $error("capture flag not cleared by write");

  a_cap_guard: assert property (
    (CE_I && IO_WR_I && (IO_ADDR_I == ADDR_CAP_LO) && !stc_cap_top(mode) && !cap_evt) |=> $stable(capture))
    else $error("capture written outside top mode");

  a_cmp_direct: assert property (
    (CE_I && IO_RD_I && (IO_ADDR_I == ADDR_CMP_HI)) |=> (IO_RDATA_O == $past(compare[15:8])))
    else $error("compare upper read went through staging");

  c_capture: cover property (CE_I && cap_evt);
  c_overflow: cover property ($rose(OVERFLOW_FLAG_O));
  c_count_write: cover property (CE_I && cnt_wr && tick);
  c_capture_irq: cover property ($rose(CAPTURE_IRQ_O));

endmodule

//--- test/stc_cpu_model.sv
// CPU-side model driving the timer core's byte access port
`timescale 1ns/1ps

module stc_cpu_model
  import stc_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire stc_byte_t io_rdata_i,
  output stc_addr_t      io_addr_o,
  output logic           io_rd_o,
  output logic           io_wr_o,
  output stc_byte_t      io_wdata_o
);
  // ==========================================================
  // Byte cycles
  // Idle bus, strobes low
  initial
  begin
    io_addr_o  = ADDR_CNT_LO;
    io_rd_o    = 1'b0;
    io_wr_o    = 1'b0;
    io_wdata_o = BYTE_RST;
  end

  // One-cycle write strobe; data flips afterwards so a late sampler sees garbage
  task automatic wr_byte(input stc_addr_t a, input stc_byte_t d);
    @(posedge mclk_i);
    io_addr_o  <= a;
    io_wdata_o <= d;
    io_wr_o    <= 1'b1;
    @(posedge mclk_i);
    io_wr_o    <= 1'b0;
    io_wdata_o <= ~d;
  endtask

  // One-cycle read strobe; data is taken once the taking edge has landed
  task automatic rd_byte(input stc_addr_t a, output stc_byte_t d);
    @(posedge mclk_i);
    io_addr_o <= a;
    io_rd_o   <= 1'b1;
    @(posedge mclk_i);
    io_rd_o   <= 1'b0;
    @(negedge mclk_i);
    d = io_rdata_i;
  endtask

  // ==========================================================
  // Word cycles
  // No handler runs here, so a pair is never split
  task automatic write16(input stc_addr_t lo, input stc_word_t v);
    wr_byte(lo + 3'h1, v[15:8]);
    wr_byte(lo, v[7:0]);
  endtask

  task automatic read16(input stc_addr_t lo, output stc_word_t v);
    stc_byte_t l;
    stc_byte_t h;
    rd_byte(lo, l);
    rd_byte(lo + 3'h1, h);
    v = {h, l};
  endtask
endmodule

//--- test/stc_core_tb_top.sv
// Self-checking bench for the timer capture core
`timescale 1ns/1ps

module stc_core_tb_top
  import stc_pkg::*;
;
  logic       clk;
  logic       rst_b;
  stc_csel_t  csel;
  logic [6:0] tick;
  stc_mode_t  mode;
  logic       pin;
  logic       cmp;
  logic       cmp_sel;
  logic       rising;
  logic       irq_en;
  logic [3:0] ctl;
  logic       ce;
  stc_addr_t  addr;
  logic       rd;
  logic       wr;
  stc_byte_t  wdata;
  stc_byte_t  rdata;
  logic       ovf;
  logic       capf;
  logic       capirq;
  logic       flr;
  logic       ceil;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  stc_word_t  w;
  stc_byte_t  b;

  // ==========================================================
  // Design and CPU model
  stc_core #(.TIMER_INDEX(1)) DUT (
    .MCLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
    .IO_ADDR_I(addr), .IO_RD_I(rd), .IO_WR_I(wr), .IO_WDATA_I(wdata),
    .CLOCK_SOURCE_I(csel), .TICK_SRC_I(tick),
    .MODE_LOW_I(mode[1:0]), .MODE_HIGH_I(mode[3:2]),
    .CAPTURE_PIN_I(pin), .COMPARATOR_OUTPUT_I(cmp), .COMPARATOR_SELECT_I(cmp_sel),
    .CAPTURE_RISING_I(rising), .CAPTURE_IRQ_ENABLE_I(irq_en),
    .CAPTURE_FLAG_CLEAR_I(ctl[2]), .CAPTURE_IRQ_ACK_I(ctl[3]),
    .OVERFLOW_FLAG_CLEAR_I(ctl[0]), .OVERFLOW_IRQ_ACK_I(ctl[1]),
    .IO_RDATA_O(rdata), .OVERFLOW_FLAG_O(ovf), .CAPTURE_FLAG_O(capf),
    .CAPTURE_IRQ_O(capirq), .FLOOR_O(flr), .CEILING_O(ceil)
  );
  stc_cpu_model cpu (
    .mclk_i(clk), .io_rdata_i(rdata), .io_addr_o(addr),
    .io_rd_o(rd), .io_wr_o(wr), .io_wdata_o(wdata)
  );

  // Free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input stc_word_t got, input stc_word_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Pulses tick sources or flag clear/ack lines for one cycle
  task automatic tk(input logic [6:0] m);
    @(posedge clk) tick <= m;
    @(posedge clk) tick <= '0;
    @(negedge clk);
  endtask

  task automatic pc(input logic [3:0] m);
    @(posedge clk) ctl <= m;
    @(posedge clk) ctl <= '0;
    @(negedge clk);
  endtask

  // Bounded wait; the caller judges the flag afterwards
  task automatic wait_cap();
    for (int i = 0; i < 10 && capf !== 1'b1; i++)
      @(negedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({11'h0, flr, ceil, ovf, capf, capirq}, 16'h0010);
    cpu.read16(ADDR_CNT_LO, w);
    chk(w, WORD_RST);
  endtask

  // Every source code; unselected taps must not count
  task automatic t_clock_sel();
    cpu.write16(ADDR_CNT_LO, 16'hfff9);
    for (int k = 1; k <= 7; k++)
    begin
      @(posedge clk) csel <= stc_csel_t'(k);
      tk(~(7'h01 << (k - 1)));
      tk(7'h01 << (k - 1));
      if (k == 6)
        chk({14'h0, ovf, ceil}, 16'h0001);
    end
    @(posedge clk) csel <= CS_STOPPED;
    tk(7'h7f);
    cpu.read16(ADDR_CNT_LO, w);
    chk(w, 16'h0000);
    chk({14'h0, ovf, flr}, 16'h0003);
    pc(4'h1);
    chk({15'h0, ovf}, 16'h0000);
  endtask

  // Write and tick land on the same edge
  task automatic t_priority();
    @(posedge clk) csel <= CS_FIRST;
    cpu.wr_byte(ADDR_CNT_HI, 8'h12);
    fork
      cpu.wr_byte(ADDR_CNT_LO, 8'h34);
      tk(7'h01);
    join
    cpu.read16(ADDR_CNT_LO, w);
    chk(w, 16'h1234);
    tk(7'h01);
    cpu.read16(ADDR_CNT_LO, w);
    chk(w, 16'h1235);
    // A tick while the enable is low must not move the counter
    @(posedge clk) ce <= 1'b0;
    tk(7'h01);
    @(posedge clk) ce <= 1'b1;
    cpu.read16(ADDR_CNT_LO, w);
    chk(w, 16'h1235);
  endtask

  // One staged byte feeds two registers; compare reads leave staging alone
  task automatic t_staging();
    cpu.wr_byte(ADDR_CNT_HI, 8'h3c);
    cpu.wr_byte(ADDR_CNT_LO, 8'h11);
    cpu.wr_byte(ADDR_CMP_LO, 8'h22);
    cpu.read16(ADDR_CNT_LO, w);
    chk(w, 16'h3c11);
    cpu.read16(ADDR_CMP_LO, w);
    chk(w, 16'h3c22);
    cpu.write16(ADDR_CMP_LO, 16'hcd02);
    cpu.write16(ADDR_CNT_LO, 16'hab01);
    cpu.rd_byte(ADDR_CNT_LO, b);
    chk({8'h0, b}, 16'h0001);
    cpu.rd_byte(ADDR_CMP_HI, b);
    chk({8'h0, b}, 16'h00cd);
    cpu.rd_byte(ADDR_CNT_HI, b);
    chk({8'h0, b}, 16'h00ab);
  endtask

  // Compare-top clear mode, then an up-down mode
  task automatic t_modes();
    cpu.write16(ADDR_CMP_LO, 16'h0002);
    cpu.write16(ADDR_CNT_LO, 16'h0000);
    @(posedge clk) mode <= MODE_CTC_CMP;
    tk(7'h01);
    tk(7'h01);
    chk({14'h0, ceil, flr}, 16'h0002);
    tk(7'h01);
    chk({13'h0, ovf, ceil, flr}, 16'h0001);
    @(posedge clk) mode <= MODE_PC8;
    cpu.write16(ADDR_CNT_LO, 16'h00fe);
    tk(7'h01);
    chk({15'h0, ceil}, 16'h0001);
    tk(7'h01);
    cpu.read16(ADDR_CNT_LO, w);
    chk(w, 16'h00fe);
    cpu.write16(ADDR_CNT_LO, 16'h0000);
    tk(7'h01);
    cpu.read16(ADDR_CNT_LO, w);
    chk(w, 16'h0001);
    chk({15'h0, ovf}, 16'h0001);
    pc(4'h2);
    chk({15'h0, ovf}, 16'h0000);
    // Single-slope fixed top: wrap at 0xff flags overflow there
    @(posedge clk) mode <= MODE_FAST8;
    cpu.write16(ADDR_CNT_LO, 16'h00ff);
    tk(7'h01);
    chk({14'h0, ovf, flr}, 16'h0003);
    pc(4'h1);
    chk({15'h0, ovf}, 16'h0000);
  endtask

  // Pin edges, enable, clear by write and by acknowledge
  task automatic t_capture();
    @(posedge clk) mode <= MODE_NORMAL;
    @(posedge clk) csel <= CS_STOPPED;
    cpu.write16(ADDR_CNT_LO, 16'h5a3c);
    @(posedge clk) pin <= 1'b1;
    wait_cap();
    chk({14'h0, capf, capirq}, 16'h0002);
    cpu.read16(ADDR_CAP_LO, w);
    chk(w, 16'h5a3c);
    pc(4'h4);
    chk({15'h0, capf}, 16'h0000);
    @(posedge clk) rising <= 1'b0;
    @(posedge clk) irq_en <= 1'b1;
    cpu.write16(ADDR_CNT_LO, 16'h0777);
    @(posedge clk) pin <= 1'b0;
    wait_cap();
    chk({14'h0, capf, capirq}, 16'h0003);
    pc(4'h8);
    chk({14'h0, capf, capirq}, 16'h0000);
    @(posedge clk) pin <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({15'h0, capf}, 16'h0000);
  endtask

  // Comparator as source, then writes to the capture register by mode
  task automatic t_comparator();
    @(posedge clk) rising <= 1'b1;
    @(posedge clk) cmp_sel <= 1'b1;
    pc(4'h4);
    @(posedge clk) cmp <= 1'b1;
    wait_cap();
    chk({15'h0, capf}, 16'h0001);
    pc(4'h4);
    cpu.write16(ADDR_CAP_LO, 16'h1111);
    cpu.read16(ADDR_CAP_LO, w);
    chk(w, 16'h0777);
    @(posedge clk) mode <= MODE_CTC_CAP;
    cpu.write16(ADDR_CAP_LO, 16'h00c0);
    cpu.read16(ADDR_CAP_LO, w);
    chk(w, 16'h00c0);
    cpu.rd_byte(3'h6, b);
    chk({8'h0, b}, 16'h0000);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_b   = 1'b0;
    csel    = CS_STOPPED;
    tick    = '0;
    mode    = MODE_NORMAL;
    pin     = 1'b0;
    cmp     = 1'b0;
    cmp_sel = 1'b0;
    rising  = 1'b1;
    irq_en  = 1'b0;
    ctl     = '0;
    ce      = 1'b1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    t_reset();
    t_clock_sel();
    t_priority();
    t_staging();
    t_modes();
    t_capture();
    t_comparator();
    summarize();
  end
endmodule
